// ===== core/step_decoder_map.vh
// register offsets, field positions, reset values and command encodings of the step decoder
`ifndef STEP_DECODER_MAP_VH
`define STEP_DECODER_MAP_VH

`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_STEP_CMD    12'h008
`define OFS_C0LIM       12'h00C
`define OFS_C1LIM       12'h010
`define OFS_T0LIM       12'h014
`define OFS_T1LIM       12'h018
`define OFS_SDLIM       12'h01C
`define OFS_LIT0        12'h020
`define OFS_BTE         12'h024
`define OFS_ADJ         12'h028
`define OFS_HOLD        12'h02C
`define OFS_STROBE      12'h030

`define CTRL_SWT_BIT    0
`define CTRL_SD_EN_BIT  1
`define STAT_BUSY_BIT   0
`define STAT_SDEN_BIT   1
`define STAT_WAIT_BIT   2

`define GRP_CTRL        4'h0
`define GRP_ADD         4'h4
`define GRP_COPY        4'h5

`define OPT_SD_OFF      4'h2
`define OPT_SD_ON       4'h6
`define OPT_WAIT_T0     4'h8
`define OPT_WAIT_T1     4'h9
`define OPT_SWT_LVL     4'hA
`define OPT_SWT_EDGE    4'hB
`define OPT_STRB_C0     4'hC
`define OPT_STRB_C1     4'hD
`define OPT_STRB_L0     4'hE
`define OPT_BCAST       4'hF

`define RST_WORD        16'h0000

`endif

// ===== core/trigger_sequence_step_decoder.v
// trigger sequencer step command decoder and executor with apb register access
`timescale 1ns/1ps
`include "step_decoder_map.vh"

module trigger_sequence_step_decoder
(
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [15:0] strobe_out,
    output reg         strobe_valid,
    output reg  [15:0] trigger_out,
    output reg         step_done
);

////////////////////////////////////////////////////////////////////////////////
localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_EXEC = 2'd1;
localparam [1:0] ST_WAIT = 2'd2;

reg  [15:0] c0lim_q;
reg  [15:0] c1lim_q;
reg  [15:0] t0lim_q;
reg  [15:0] t1lim_q;
reg  [15:0] sdlim_q;
reg  [15:0] lit0_q;
reg  [15:0] bte_q;
reg  [15:0] adj_q;
reg  [15:0] hold_q;
reg         swt_q;
reg         swt_prev_q;
reg         sd_en_q;
reg  [7:0]  cmd_q;
reg         cmd_pend_q;
reg  [1:0]  state_q;
reg  [15:0] tmr_q;
reg         wait_edge_q;
reg  [3:0]  wait_kind_q;

wire        setup    = psel & ~penable;
wire        wr_take  = psel & penable & pwrite & pready;
wire [3:0]  opt      = cmd_q[3:0];
wire [3:0]  grp      = cmd_q[7:4];
wire        swt_rise = swt_q & ~swt_prev_q;

function known_addr;
    input [11:0] a;
    begin
        known_addr = (a <= `OFS_STROBE) && (a[1:0] == 2'b00);
    end
endfunction

// a destination index 0..5 picks c0, c1, t0, t1, step delay, literal0
function [15:0] pick;
    input [2:0]  idx;
    input [15:0] cur;
    input [2:0]  sel;
    input [15:0] val;
    begin
        pick = (idx == sel) ? val : cur;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// status word; busy also covers the cycle between an accepted step write and its execution
reg  [31:0] status_word;

always @*
begin
    status_word                 = 32'h0000_0000;
    status_word[`STAT_BUSY_BIT] = (state_q != ST_IDLE) | cmd_pend_q;
    status_word[`STAT_SDEN_BIT] = sd_en_q;
    status_word[`STAT_WAIT_BIT] = (state_q == ST_WAIT);
end

////////////////////////////////////////////////////////////////////////////////
// apb slave: no wait states, answers in the first access cycle after setup
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end
    else
    begin
        pready  <= setup;
        pslverr <= setup & ~known_addr(paddr);
        prdata  <= 32'h0000_0000;
        if (setup & ~pwrite)
        begin
            case (paddr)
                `OFS_CTRL:     prdata <= {30'd0, sd_en_q, swt_q};
                `OFS_STATUS:   prdata <= status_word;
                `OFS_STEP_CMD: prdata <= {24'd0, cmd_q};
                `OFS_C0LIM:    prdata <= {16'd0, c0lim_q};
                `OFS_C1LIM:    prdata <= {16'd0, c1lim_q};
                `OFS_T0LIM:    prdata <= {16'd0, t0lim_q};
                `OFS_T1LIM:    prdata <= {16'd0, t1lim_q};
                `OFS_SDLIM:    prdata <= {16'd0, sdlim_q};
                `OFS_LIT0:     prdata <= {16'd0, lit0_q};
                `OFS_BTE:      prdata <= {16'd0, bte_q};
                `OFS_ADJ:      prdata <= {16'd0, adj_q};
                `OFS_HOLD:     prdata <= {16'd0, hold_q};
                `OFS_STROBE:   prdata <= {16'd0, strobe_out};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// register file, step sequencer and timer; software writes to limits lose to an add or copy step in the same cycle
always @(posedge mclk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        c0lim_q      <= `RST_WORD;
        c1lim_q      <= `RST_WORD;
        t0lim_q      <= `RST_WORD;
        t1lim_q      <= `RST_WORD;
        sdlim_q      <= `RST_WORD;
        lit0_q       <= `RST_WORD;
        bte_q        <= `RST_WORD;
        adj_q        <= `RST_WORD;
        hold_q       <= `RST_WORD;
        swt_q        <= 1'b0;
        swt_prev_q   <= 1'b0;
        sd_en_q      <= 1'b0;
        cmd_q        <= 8'h00;
        cmd_pend_q   <= 1'b0;
        state_q      <= ST_IDLE;
        tmr_q        <= `RST_WORD;
        wait_edge_q  <= 1'b0;
        wait_kind_q  <= 4'h0;
        strobe_out   <= `RST_WORD;
        strobe_valid <= 1'b0;
        trigger_out  <= `RST_WORD;
        step_done    <= 1'b0;
    end
    else
    begin
        swt_prev_q   <= swt_q;
        strobe_valid <= 1'b0;
        trigger_out  <= `RST_WORD;
        step_done    <= 1'b0;
        if (wr_take)
        begin
            case (paddr)
                `OFS_CTRL:
                begin
                    swt_q   <= pwdata[`CTRL_SWT_BIT];
                    sd_en_q <= pwdata[`CTRL_SD_EN_BIT];
                end
                `OFS_STEP_CMD:
                begin
                    // a new step is refused while one is pending or running
                    if (!cmd_pend_q && state_q == ST_IDLE)
                    begin
                        cmd_q      <= pwdata[7:0];
                        cmd_pend_q <= 1'b1;
                    end
                end
                `OFS_C0LIM: c0lim_q <= pwdata[15:0];
                `OFS_C1LIM: c1lim_q <= pwdata[15:0];
                `OFS_T0LIM: t0lim_q <= pwdata[15:0];
                `OFS_T1LIM: t1lim_q <= pwdata[15:0];
                `OFS_SDLIM: sdlim_q <= pwdata[15:0];
                `OFS_LIT0:  lit0_q  <= pwdata[15:0];
                `OFS_BTE:   bte_q   <= pwdata[15:0];
                `OFS_ADJ:   adj_q   <= pwdata[15:0];
                `OFS_HOLD:  hold_q  <= pwdata[15:0];
                default:    ;
            endcase
        end
        case (state_q)
            ST_IDLE:
            begin
                if (cmd_pend_q)
                    state_q <= ST_EXEC;
            end
            ST_EXEC:
            begin
                cmd_pend_q <= 1'b0;
                state_q    <= ST_IDLE;
                step_done  <= 1'b1;
                if (grp == `GRP_CTRL)
                begin
                    case (opt)
                        `OPT_SD_OFF: sd_en_q <= 1'b0;
                        `OPT_SD_ON:  sd_en_q <= 1'b1;
                        `OPT_WAIT_T0, `OPT_WAIT_T1, `OPT_SWT_LVL, `OPT_SWT_EDGE:
                        begin
                            tmr_q       <= `RST_WORD;
                            wait_kind_q <= opt;
                            wait_edge_q <= 1'b0;
                            step_done   <= 1'b0;
                            state_q     <= ST_WAIT;
                        end
                        `OPT_STRB_C0:
                        begin
                            strobe_out   <= c0lim_q;
                            strobe_valid <= 1'b1;
                        end
                        `OPT_STRB_C1:
                        begin
                            strobe_out   <= c1lim_q;
                            strobe_valid <= 1'b1;
                        end
                        `OPT_STRB_L0:
                        begin
                            strobe_out   <= lit0_q;
                            strobe_valid <= 1'b1;
                        end
                        `OPT_BCAST:  trigger_out <= bte_q;
                        default:     ;
                    endcase
                end
                else if (grp == `GRP_ADD && !opt[3] && opt[2:0] <= 3'd5)
                begin
                    c0lim_q <= pick(3'd0, c0lim_q, opt[2:0], c0lim_q + adj_q);
                    c1lim_q <= pick(3'd1, c1lim_q, opt[2:0], c1lim_q + adj_q);
                    t0lim_q <= pick(3'd2, t0lim_q, opt[2:0], t0lim_q + adj_q);
                    t1lim_q <= pick(3'd3, t1lim_q, opt[2:0], t1lim_q + adj_q);
                    sdlim_q <= pick(3'd4, sdlim_q, opt[2:0], sdlim_q + adj_q);
                    lit0_q  <= pick(3'd5, lit0_q,  opt[2:0], lit0_q + adj_q);
                end
                else if (grp == `GRP_COPY && opt[3] && opt[2:0] <= 3'd5)
                begin
                    c0lim_q <= pick(3'd0, c0lim_q, opt[2:0], hold_q);
                    c1lim_q <= pick(3'd1, c1lim_q, opt[2:0], hold_q);
                    t0lim_q <= pick(3'd2, t0lim_q, opt[2:0], hold_q);
                    t1lim_q <= pick(3'd3, t1lim_q, opt[2:0], hold_q);
                    sdlim_q <= pick(3'd4, sdlim_q, opt[2:0], hold_q);
                    lit0_q  <= pick(3'd5, lit0_q,  opt[2:0], hold_q);
                end
            end
            ST_WAIT:
            begin
                case (wait_kind_q)
                    `OPT_WAIT_T0, `OPT_WAIT_T1:
                    begin
                        // the timer counts from zero; it stops when it equals its limit
                        if (tmr_q == ((wait_kind_q == `OPT_WAIT_T0) ? t0lim_q : t1lim_q))
                        begin
                            state_q    <= ST_IDLE;
                            cmd_pend_q <= 1'b0;
                            step_done  <= 1'b1;
                        end
                        else
                            tmr_q <= tmr_q + 16'h0001;
                    end
                    `OPT_SWT_LVL:
                    begin
                        if (swt_q)
                        begin
                            state_q    <= ST_IDLE;
                            cmd_pend_q <= 1'b0;
                            step_done  <= 1'b1;
                        end
                    end
                    default:
                    begin
                        // a level already high on entry does not count; a fresh 0 to 1 is needed
                        if (swt_rise)
                        begin
                            state_q    <= ST_IDLE;
                            cmd_pend_q <= 1'b0;
                            step_done  <= 1'b1;
                        end
                    end
                endcase
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end

endmodule // trigger_sequence_step_decoder

// ===== tb/peripheral_sink.sv
// model of the peripherals that take strobe values and broadcast triggers
`timescale 1ns/1ps
module peripheral_sink
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [15:0] strobe_out,
    input wire logic        strobe_valid,
    input wire logic [15:0] trigger_out,
    output logic     [15:0] last_strobe,
    output logic     [15:0] last_trig,
    output logic     [7:0]  strobe_cnt
);
    // a peripheral only sees the strobe in its valid cycle, so capture nothing else
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            last_strobe <= 16'h0000;
            last_trig   <= 16'h0000;
            strobe_cnt  <= 8'h00;
        end
        else
        begin
            if (strobe_valid)
            begin
                last_strobe <= strobe_out;
                strobe_cnt  <= strobe_cnt + 8'h01;
            end
            if (trigger_out != 16'h0000)
                last_trig <= trigger_out;
        end
    end
endmodule // peripheral_sink

// ===== tb/step_decoder_chk.sv
// port-level assertions for the trigger sequence step decoder
`timescale 1ns/1ps
`include "step_decoder_map.vh"
module step_decoder_chk
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] strobe_out,
    input wire logic        strobe_valid,
    input wire logic [15:0] trigger_out,
    input wire logic        step_done
);
    logic       busy_q;
    logic [7:0] cmd_q;
    wire        step_wr = psel && penable && pready && pwrite && paddr == `OFS_STEP_CMD && !busy_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////////////
    // a write while busy is dropped by the design, so only idle writes load the tracker
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_q <= 1'b0;
            cmd_q  <= 8'h00;
        end
        else if (step_wr)
        begin
            busy_q <= 1'b1;
            cmd_q  <= pwdata[7:0];
        end
        else if (step_done)
            busy_q <= 1'b0;
    end
////////////////////////////////////////////////////////////////////////////////
    a_strobe_hold: assert property (!strobe_valid |-> $stable(strobe_out))
        else $error("strobe value moved without a strobe step");
    a_strobe_cmd: assert property (step_wr && pwdata[7:0] inside {8'h0C, 8'h0D, 8'h0E} |-> ##[2:3] strobe_valid && step_done)
        else $error("strobe step gave no strobe");
    a_step_latency: assert property (step_wr && !(pwdata[7:0] inside {8'h08, 8'h09, 8'h0A, 8'h0B}) |=> !step_done ##[1:2] step_done)
        else $error("plain step did not finish in time");
    a_done_pulse: assert property (step_done |=> !step_done)
        else $error("step done longer than one cycle");
    a_done_cause: assert property (step_done |-> busy_q)
        else $error("step done without an accepted step");
    a_trig_cause: assert property (trigger_out != 16'h0000 |-> step_done && cmd_q == 8'h0F)
        else $error("trigger outside a broadcast step");
    a_strobe_cause: assert property (strobe_valid |-> step_done && cmd_q inside {8'h0C, 8'h0D, 8'h0E})
        else $error("strobe outside a strobe step");
    a_trig_pulse: assert property (trigger_out != 16'h0000 |=> trigger_out == 16'h0000)
        else $error("trigger held past one cycle");
    c_bcast: cover property (step_wr && pwdata[7:0] == 8'h0F);
    c_strobe: cover property (strobe_valid);
    c_refused: cover property (pready && pslverr);
endmodule // step_decoder_chk

bind trigger_sequence_step_decoder step_decoder_chk step_decoder_chk_i (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strobe_out(strobe_out), .strobe_valid(strobe_valid),
    .trigger_out(trigger_out), .step_done(step_done));

// ===== tb/tb_top.sv
// self-checking bench for the trigger sequence step decoder
`timescale 1ns/1ps
`include "step_decoder_map.vh"
module tb_top;
    logic        mclk     = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0000_0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [15:0] strobe_out;
    wire         strobe_valid;
    wire  [15:0] trigger_out;
    wire         step_done;
    wire  [15:0] last_strobe;
    wire  [15:0] last_trig;
    wire  [7:0]  strobe_cnt;
    int          failures    = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          n;
    logic [31:0] rd;
    logic        err;
    logic [11:0] lim_a [6] = '{`OFS_C0LIM, `OFS_C1LIM, `OFS_T0LIM, `OFS_T1LIM, `OFS_SDLIM, `OFS_LIT0};
    logic [15:0] lim_v [6] = '{16'h1111, 16'h2222, 16'h0014, 16'h000A, 16'h0005, 16'h6666};
    logic [7:0]  nops  [12] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07, 8'h46, 8'h47, 8'h5E, 8'h5F, 8'h2C, 8'h1F};

    trigger_sequence_step_decoder trigger_sequence_step_decoder_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strobe_out(strobe_out), .strobe_valid(strobe_valid), .trigger_out(trigger_out),
        .step_done(step_done));
    peripheral_sink peripheral_sink_i (.mclk(mclk), .sys_rst(sys_rst), .strobe_out(strobe_out),
        .strobe_valid(strobe_valid), .trigger_out(trigger_out), .last_strobe(last_strobe),
        .last_trig(last_trig), .strobe_cnt(strobe_cnt));
////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait for the answer
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // stops on the edge that samples step_done high, or after lim edges
    task automatic wait_done(input int lim);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (step_done !== 1'b1 && n < lim);
    endtask

    task automatic step(input logic [7:0] c);
        apb(1'b1, `OFS_STEP_CMD, {24'h00_0000, c});
        wait_done(40);
        check(step_done, 1'b1);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b0, `OFS_STATUS, 0);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h034, 0);
        check({rd, err}, 33'h0_0000_0001);
        for (int i = 0; i < 6; i++) apb(1'b1, lim_a[i], {16'h0000, lim_v[i]});
        apb(1'b1, `OFS_BTE, 32'h0000_00A5);
        apb(1'b1, `OFS_ADJ, 32'h0000_0010);
        apb(1'b1, `OFS_HOLD, 32'h0000_0777);
        step(8'h0C);
        check(strobe_out, 16'h1111);
        step(8'h0D);
        check(strobe_out, 16'h2222);
        step(8'h0E);
        check(strobe_out, 16'h6666);
        step(8'h0F);
        check(trigger_out, 16'h00A5);
        apb(1'b0, `OFS_STROBE, 0);
        check({rd[15:0], last_strobe, last_trig, strobe_cnt}, {48'h6666_6666_00A5, 8'h03});
        step(8'h06);
        apb(1'b0, `OFS_STATUS, 0);
        check(rd[`STAT_SDEN_BIT], 1'b1);
        step(8'h02);
        apb(1'b0, `OFS_STATUS, 0);
        check(rd[`STAT_SDEN_BIT], 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, `OFS_STEP_CMD, 8 + i);
            apb(1'b1, `OFS_STEP_CMD, 32'h0000_000C); // dropped while the wait runs
            apb(1'b0, `OFS_STATUS, 0);
            check(rd[2:0], 3'b101);
            wait_done(200);
            check(n, lim_v[2 + i] - 16'h0002);
            check(strobe_out, 16'h6666);
        end
        apb(1'b1, `OFS_CTRL, 1);
        step(8'h0A);
        apb(1'b1, `OFS_CTRL, 0);
        apb(1'b1, `OFS_STEP_CMD, 32'h0000_000A);
        wait_done(30);
        check(step_done, 1'b0);
        apb(1'b1, `OFS_CTRL, 1);
        wait_done(20);
        check(step_done, 1'b1);
        apb(1'b1, `OFS_STEP_CMD, 32'h0000_000B);
        wait_done(30);
        check(step_done, 1'b0);
        apb(1'b1, `OFS_CTRL, 0);
        apb(1'b1, `OFS_CTRL, 1);
        wait_done(20);
        check(step_done, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            step(8'h40 + i);
            apb(1'b0, lim_a[i], 0);
            check(rd, {16'h0000, lim_v[i] + 16'h0010});
            step(8'h58 + i);
            apb(1'b0, lim_a[i], 0);
            check(rd, 32'h0000_0777);
        end
        foreach (nops[j]) step(nops[j]);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, lim_a[i], 0);
            check(rd, 32'h0000_0777);
        end
        apb(1'b0, `OFS_STROBE, 0);
        check({rd[15:0], last_trig, strobe_cnt}, {32'h6666_00A5, 8'h03});
        end_of_test();
    end
endmodule // tb_top
